// [verilog/tape_port_pkg.sv]
// Operation
// - Host reads sense byte 0, then the further bytes that it counts.
// - Each base group decodes only while its own select is low.
// - Even base 0 ports: parameter writes, drive status reads.
// - Odd base 0 ports: command writes, controller status reads.
// - Every base 1 address reads or writes a data byte.
// - All mirrored addresses of one port behave identically.
// - DMA bytes follow dma_request; acknowledge is optional.
// - Host honours dma_terminate, raised on an unrecoverable drive error.
// - No data moves before the begin command's parameter arrives.
// - Code 40 is transfer begin: one parameter, both drive types.
// - Special commands act only inside a transfer command; no status.
// - output_buffer_full sets on controller write, clears on host read.
// - input_buffer_full stays set from host write until controller take.
package tape_port_pkg;

  // Register offsets within each base group.
  localparam logic [3:0] PARAM_PORT_OFS = 4'h0;
  localparam logic [3:0] CMD_PORT_OFS   = 4'h1;
  localparam logic [3:0] DATA_PORT_OFS  = 4'h0;

  // Controller status byte layout.
  localparam int OUT_FULL_BIT = 0;
  localparam int IN_FULL_BIT  = 1;
  localparam int READY_BIT    = 7;

  // Command codes the port watches while forwarding them.
  localparam logic [7:0] CMD_WRITE_BLOCK    = 8'h02;
  localparam logic [7:0] CMD_READ_BLOCK     = 8'h04;
  localparam logic [7:0] CMD_WRITE_RAM      = 8'h15;
  localparam logic [7:0] CMD_READ_RAM       = 8'h16;
  localparam logic [7:0] transfer_begin_cmd = 8'h40;
  localparam logic [7:0] transfer_end_cmd   = 8'h80;

  // Reset values.
  localparam logic [7:0] BYTE_RESET = 8'h00;

  // Transfer sequencing, Gray coded from idle up to the end parameter state.
  typedef enum logic [2:0] {
    XF_IDLE        = 3'b000,
    XF_ARMED       = 3'b001,
    XF_BEGIN_PARAM = 3'b011,
    XF_MOVING      = 3'b010,
    XF_END_PARAM   = 3'b110
  } xfer_state_t;

endpackage

// [verilog/tape_host_command_port.sv]
`timescale 1ns/1ps
module tape_host_command_port #(
  parameter bit WIDE_HOST = 1'b0
) (
  input  wire logic       ref_clk_i,
  input  wire logic       srst_i,
  input  wire logic       base0_select_n_i,
  input  wire logic       base1_select_n_i,
  input  wire logic [3:0] addr_i,
  input  wire logic       io_read_n_i,
  input  wire logic       io_write_n_i,
  input  wire logic [7:0] data_i,
  output logic      [7:0] data_o,
  output logic            data_oe_o,
  output logic            dma_request_o,
  input  wire logic       dma_acknowledge_n_i,
  output logic            dma_terminate_o,
  output logic            completion_interrupt_o,
  output logic            in_valid_o,
  output logic      [7:0] in_byte_o,
  output logic            in_is_cmd_o,
  input  wire logic       in_take_i,
  input  wire logic       out_valid_i,
  input  wire logic [7:0] out_byte_i,
  output logic            out_ready_o,
  input  wire logic       buffer_ready_i,
  input  wire logic       hard_error_i,
  input  wire logic       rd_valid_i,
  input  wire logic [7:0] rd_data_i,
  output logic            rd_ready_o,
  output logic            wr_valid_o,
  output logic      [7:0] wr_data_o,
  input  wire logic       wr_ready_i
);

  // Selects the odd (command) port bit; a 16-bit host steps by two.
  function automatic logic port_is_odd(input logic [3:0] a);
    port_is_odd = WIDE_HOST ? a[1] : a[0];
  endfunction

  logic                      rd_n_q_ff;
  logic                      wr_n_q_ff;
  logic                      in_full_ff;
  logic                      out_full_ff;
  logic [7:0]                in_byte_ff;
  logic                      in_cmd_ff;
  logic [7:0]                out_byte_ff;
  logic                      dir_read_ff;
  logic                      term_ff;
  logic                      req_ff;
  logic [7:0]                data_ff;
  logic                      oe_ff;
  logic                      out_rdy_ff;
  logic                      rd_rdy_ff;
  logic                      wr_vld_ff;
  logic [7:0]                wr_head_ff;
  logic [7:0]                fifo_mem [2];
  logic                      wptr_ff;
  logic                      rptr_ff;
  logic [1:0]                cnt_ff;
  tape_port_pkg::xfer_state_t state_ff;
  tape_port_pkg::xfer_state_t nxt_state;

  // Access strobes fire once, on the first cycle a strobe goes low.
  wire rd_start  = !io_read_n_i && rd_n_q_ff;
  wire wr_start  = !io_write_n_i && wr_n_q_ff;
  wire sel0      = !base0_select_n_i;
  wire sel1      = !base1_select_n_i;
  wire odd_port  = port_is_odd(addr_i);
  wire wr_param  = wr_start && sel0 && !odd_port;
  wire wr_cmd    = wr_start && sel0 && odd_port;
  wire rd_drive  = rd_start && sel0 && !odd_port;
  wire rd_ctl    = rd_start && sel0 && odd_port;
  wire rd_data   = rd_start && sel1;
  wire wr_data   = wr_start && sel1;
  wire ctl_write = out_valid_i && !out_full_ff;
  wire ctl_take  = in_take_i && in_full_ff;

  // Commands are snooped as the controller takes them from the buffer.
  wire take_cmd   = ctl_take && in_cmd_ff;
  wire take_param = ctl_take && !in_cmd_ff;
  wire is_xfer_cmd = (in_byte_ff == tape_port_pkg::CMD_WRITE_BLOCK) ||
                     (in_byte_ff == tape_port_pkg::CMD_READ_BLOCK) ||
                     (in_byte_ff == tape_port_pkg::CMD_WRITE_RAM) ||
                     (in_byte_ff == tape_port_pkg::CMD_READ_RAM);
  wire is_read_cmd = (in_byte_ff == tape_port_pkg::CMD_READ_BLOCK) ||
                     (in_byte_ff == tape_port_pkg::CMD_READ_RAM);
  wire moving      = (state_ff == tape_port_pkg::XF_MOVING);
  wire xfer_on     = (state_ff != tape_port_pkg::XF_IDLE);

  // The acknowledge input is not needed; only the strobes move bytes.
  wire unused_ack  = dma_acknowledge_n_i;

  // Two-entry buffer sits between host data strobes and the tape side.
  wire fifo_full  = (cnt_ff == 2'd2);
  wire fifo_empty = (cnt_ff == 2'd0);
  wire push_host  = wr_data && moving && !dir_read_ff && !fifo_full;
  wire push_tape  = rd_valid_i && moving && dir_read_ff && !fifo_full;
  wire pop_host   = rd_data && moving && dir_read_ff && !fifo_empty;
  wire pop_tape   = wr_ready_i && moving && !dir_read_ff && !fifo_empty;
  wire push       = push_host || push_tape;
  wire pop        = pop_host || pop_tape;
  wire [7:0] push_byte = dir_read_ff ? rd_data_i : data_i;
  wire flush      = !moving;

  // Read data mux for whichever port the host is reading.
  wire [7:0] ctl_status = {buffer_ready_i, 5'h00, in_full_ff, out_full_ff};
  wire [7:0] rd_mux = rd_drive ? out_byte_ff :
                      rd_ctl   ? ctl_status :
                      (rd_data && dir_read_ff && !fifo_empty) ?
                        fifo_mem[rptr_ff] : tape_port_pkg::BYTE_RESET;

  // A request drops for the cycle after each byte so a fast host cannot
  // take two bytes on one stale request.
  wire nxt_req = moving && !term_ff && !(rd_data || wr_data) &&
                 (dir_read_ff ? (cnt_ff > 2'd1 || (!fifo_empty && !pop))
                              : (cnt_ff == 2'd0));

  // Next values of the stream outputs; registering them keeps every pin a
  // flop while showing the same buffer state in the same cycle.
  wire       nxt_out_full = ctl_write || (out_full_ff && !rd_drive);
  wire       nxt_moving   = (nxt_state == tape_port_pkg::XF_MOVING);
  wire       nxt_dir_read = (take_cmd && is_xfer_cmd && !xfer_on) ?
                            is_read_cmd : dir_read_ff;
  wire [1:0] nxt_cnt      = flush ? 2'd0 :
                            cnt_ff + {1'b0, push} - {1'b0, pop};
  wire       nxt_rptr     = flush ? 1'b0 : (rptr_ff ^ pop);
  wire [7:0] nxt_head     = (push && (wptr_ff == nxt_rptr)) ? push_byte :
                            fifo_mem[nxt_rptr];

  // Transfer sequencing; data waits for the begin command's parameter.
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      tape_port_pkg::XF_IDLE: begin
        if (take_cmd && is_xfer_cmd) begin
          nxt_state = tape_port_pkg::XF_ARMED;
        end
      end
      tape_port_pkg::XF_ARMED: begin
        if (take_cmd &&
            in_byte_ff == tape_port_pkg::transfer_begin_cmd) begin
          nxt_state = tape_port_pkg::XF_BEGIN_PARAM;
        end
      end
      tape_port_pkg::XF_BEGIN_PARAM: begin
        if (take_param) begin
          nxt_state = tape_port_pkg::XF_MOVING;
        end
      end
      tape_port_pkg::XF_MOVING: begin
        if (take_cmd && in_byte_ff == tape_port_pkg::transfer_end_cmd) begin
          nxt_state = tape_port_pkg::XF_END_PARAM;
        end
      end
      tape_port_pkg::XF_END_PARAM: begin
        if (take_param) begin
          nxt_state = tape_port_pkg::XF_ARMED;
        end
      end
      default: begin
        nxt_state = tape_port_pkg::XF_IDLE;
      end
    endcase
    // Status from the controller or a hard error ends the transfer command.
    if (ctl_write || hard_error_i) begin
      nxt_state = tape_port_pkg::XF_IDLE;
    end
  end

  // Strobe history and transfer state.
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      rd_n_q_ff <= 1'b1;
      wr_n_q_ff <= 1'b1;
      state_ff  <= tape_port_pkg::XF_IDLE;
    end else begin
      rd_n_q_ff <= io_read_n_i;
      wr_n_q_ff <= io_write_n_i;
      state_ff  <= nxt_state;
    end
  end

  // Input buffer: a host write wins over a same-cycle controller take.
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      in_full_ff <= 1'b0;
      in_byte_ff <= tape_port_pkg::BYTE_RESET;
      in_cmd_ff  <= 1'b0;
    end else if (wr_param || wr_cmd) begin
      in_full_ff <= 1'b1;
      in_byte_ff <= data_i;
      in_cmd_ff  <= wr_cmd;
    end else if (ctl_take) begin
      in_full_ff <= 1'b0;
    end
  end

  // Output buffer carries sense bytes; byte 0 holds the count. The
  // controller's write wins over a same-cycle host read.
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      out_full_ff <= 1'b0;
      out_byte_ff <= tape_port_pkg::BYTE_RESET;
    end else if (ctl_write) begin
      out_full_ff <= 1'b1;
      out_byte_ff <= out_byte_i;
    end else if (rd_drive) begin
      out_full_ff <= 1'b0;
    end
  end

  // Direction is latched from the data transfer command; special commands
  // outside a transfer are still consumed but change nothing.
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      dir_read_ff <= 1'b0;
    end else if (take_cmd && is_xfer_cmd && !xfer_on) begin
      dir_read_ff <= is_read_cmd;
    end
  end

  // Buffer storage and pointers; leaving the moving state empties it.
  always_ff @(posedge ref_clk_i) begin
    if (srst_i || flush) begin
      wptr_ff <= 1'b0;
      rptr_ff <= 1'b0;
      cnt_ff  <= 2'd0;
    end else begin
      if (push) begin
        fifo_mem[wptr_ff] <= push_byte;
        wptr_ff           <= !wptr_ff;
      end
      if (pop) begin
        rptr_ff <= !rptr_ff;
      end
      cnt_ff <= cnt_ff + {1'b0, push} - {1'b0, pop};
    end
  end

  // Pin outputs, all registered.
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      data_ff <= tape_port_pkg::BYTE_RESET;
      oe_ff   <= 1'b0;
      req_ff  <= 1'b0;
      term_ff <= 1'b0;
    end else begin
      if (rd_start) begin
        data_ff <= rd_mux;
      end
      oe_ff   <= !io_read_n_i && (sel0 || sel1);
      req_ff  <= nxt_req;
      term_ff <= hard_error_i && moving;
    end
  end

  // Stream outputs, loaded from their next values.
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      out_rdy_ff <= 1'b1;
      rd_rdy_ff  <= 1'b0;
      wr_vld_ff  <= 1'b0;
      wr_head_ff <= tape_port_pkg::BYTE_RESET;
    end else begin
      out_rdy_ff <= !nxt_out_full;
      rd_rdy_ff  <= nxt_moving && nxt_dir_read && (nxt_cnt != 2'd2);
      wr_vld_ff  <= nxt_moving && !nxt_dir_read && (nxt_cnt != 2'd0);
      wr_head_ff <= nxt_head;
    end
  end

  assign data_o                 = data_ff;
  assign data_oe_o              = oe_ff;
  assign dma_request_o          = req_ff;
  assign dma_terminate_o        = term_ff;
  assign completion_interrupt_o = out_full_ff;
  assign in_valid_o             = in_full_ff;
  assign in_byte_o              = in_byte_ff;
  assign in_is_cmd_o            = in_cmd_ff;
  assign out_ready_o            = out_rdy_ff;
  assign rd_ready_o             = rd_rdy_ff;
  assign wr_valid_o             = wr_vld_ff;
  assign wr_data_o              = wr_head_ff;

endmodule // tape_host_command_port

// [test/tape_port_chk.sv]
`timescale 1ns/1ps
// Host pins and buffer handshakes; access effects are judged one cycle after the start.
module tape_port_chk #(
  parameter bit WIDE_HOST = 1'b0
) (
  input wire logic       ref_clk_i,
  input wire logic       srst_i,
  input wire logic       base0_select_n_i,
  input wire logic       base1_select_n_i,
  input wire logic [3:0] addr_i,
  input wire logic       io_read_n_i,
  input wire logic       io_write_n_i,
  input wire logic [7:0] data_o,
  input wire logic       data_oe_o,
  input wire logic       dma_request_o,
  input wire logic       dma_terminate_o,
  input wire logic       completion_interrupt_o,
  input wire logic       in_valid_o,
  input wire logic       in_is_cmd_o,
  input wire logic       in_take_i,
  input wire logic       out_valid_i,
  input wire logic       out_ready_o,
  input wire logic       hard_error_i
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (srst_i);
  // A wide host moves the odd-port bit up by one.
  wire logic odd = WIDE_HOST ? addr_i[1] : addr_i[0];
  a_in_full_set:
    assert property ($fell(io_write_n_i) && !base0_select_n_i |=> in_valid_o)
      else $error("input flag not set");
  a_in_full_hold:
    assert property (in_valid_o && !in_take_i |=> in_valid_o)
      else $error("input flag lost");
  a_port_kind:
    assert property ($fell(io_write_n_i) && !base0_select_n_i
      |=> in_is_cmd_o == $past(odd)) else $error("byte kind wrong");
  a_out_full_set:
    assert property (out_valid_i && out_ready_o
      |=> completion_interrupt_o && !out_ready_o)
      else $error("output flag not set");
  a_status_byte:
    assert property ($fell(io_read_n_i) && !base0_select_n_i && odd
      |=> data_o[6:0] == {5'h00, $past(in_valid_o),
      $past(completion_interrupt_o)}) else $error("status wrong");
  a_select_gate:
    assert property ((base0_select_n_i && base1_select_n_i) [*2]
      |-> !data_oe_o) else $error("driving while unselected");
  a_oe_read:
    assert property ($fell(io_read_n_i) && !base1_select_n_i |=> data_oe_o)
      else $error("no drive on data read");
  a_req_drop:
    assert property (!base1_select_n_i && ($fell(io_read_n_i) ||
      $fell(io_write_n_i)) |=> !dma_request_o) else $error("request held");
  a_term_pulse:
    assert property (dma_terminate_o |-> $past(hard_error_i)
      ##1 !dma_terminate_o) else $error("bad terminate pulse");
endmodule // tape_port_chk

// [test/host_model.sv]
`timescale 1ns/1ps
// Host board: a strobe is held two edges, then idles at least one.
module host_model (
  input  wire logic       ref_clk_i,
  input  wire logic [7:0] dev_data_i,
  output logic            sel0_n_o,
  output logic            sel1_n_o,
  output logic      [3:0] addr_o,
  output logic            rd_n_o,
  output logic            wr_n_o,
  output logic      [7:0] data_o,
  output logic            ack_n_o
);
  // This host never uses the acknowledge line.
  initial begin
    {sel0_n_o, sel1_n_o, rd_n_o, wr_n_o, ack_n_o} = 5'h1f;
    addr_o = 4'h0;
    data_o = 8'h00;
  end
  // Read data is taken on the edge that ends the strobe.
  task automatic bus(input bit rd, input bit b1, input logic [3:0] a,
                     input logic [7:0] wd, output logic [7:0] q);
    @(posedge ref_clk_i);
    {sel0_n_o, sel1_n_o, rd_n_o, wr_n_o} <= {b1, !b1, !rd, rd};
    addr_o <= a;
    data_o <= wd;
    repeat (2) @(posedge ref_clk_i);
    q = dev_data_i;
    {sel0_n_o, sel1_n_o, rd_n_o, wr_n_o} <= 4'hf;
    data_o <= ~wd; // A released bus must not keep the old byte.
  endtask
endmodule // host_model

// [test/test_tape_host_command_port.sv]
`timescale 1ns/1ps
module test_tape_host_command_port;
  logic ref_clk_i = 1'b0, srst_i = 1'b1, in_take_i = 1'b0;
  logic out_valid_i = 1'b0, buffer_ready_i = 1'b0, hard_error_i = 1'b0;
  logic rd_valid_i = 1'b0, wr_ready_i = 1'b0;
  logic [7:0] out_byte_i = 8'h00, rd_data_i = 8'h00, r, b, c;
  wire logic base0_select_n_i, base1_select_n_i, io_read_n_i, io_write_n_i;
  wire logic dma_acknowledge_n_i, data_oe_o, dma_request_o, dma_terminate_o;
  wire logic completion_interrupt_o, in_valid_o, in_is_cmd_o, out_ready_o;
  wire logic rd_ready_o, wr_valid_o;
  wire logic [3:0] addr_i;
  wire logic [7:0] data_i, data_o, in_byte_o, wr_data_o;
  int errors = 0, n_checks = 0, seed = 32'he35f9896;
  logic [8:0] inq[$];
  logic [7:0] wq[$], rq[$];
  always #5 ref_clk_i = ~ref_clk_i;
  tape_host_command_port u_tape_host_command_port (.*);
  host_model u_host_model (
    .ref_clk_i(ref_clk_i), .dev_data_i(data_o), .sel0_n_o(base0_select_n_i),
    .sel1_n_o(base1_select_n_i), .addr_o(addr_i), .rd_n_o(io_read_n_i),
    .wr_n_o(io_write_n_i), .data_o(data_i), .ack_n_o(dma_acknowledge_n_i));
  task automatic chk(input logic [8:0] seen, exp, input string m);
    n_checks++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Controller takes each byte a cycle late; the tape write side stalls at random.
  always @(posedge ref_clk_i) begin
    in_take_i <= in_valid_o && !in_take_i;
    wr_ready_i <= 1'($random(seed));
    if (in_valid_o && in_take_i)
      chk({in_is_cmd_o, in_byte_o}, inq.pop_front(), "in");
    if (wr_valid_o && wr_ready_i)
      chk({1'b0, wr_data_o}, {1'b0, wq.pop_front()}, "wr");
  end
  // Polls for an empty input buffer and writes a mirrored port, or returns unwritten once the output flag reads set.
  task automatic put(input bit cmd, input logic [7:0] v);
    for (int i = 0; i < 20; i++) begin
      u_host_model.bus(1, 0, 4'h1, 8'h00, r);
      if (r[0] === 1'b1) return;
      if (r[1] === 1'b0) break;
    end
    inq.push_back({cmd, v});
    u_host_model.bus(0, 0, {1'b0, 2'($random(seed)), cmd}, v, r);
  endtask
  // Posting a sense byte also closes any transfer in progress.
  task automatic sense;
    b = 8'($random(seed));
    out_valid_i <= 1'b1;
    out_byte_i <= b;
    @(posedge ref_clk_i);
    out_valid_i <= 1'b0;
    u_host_model.bus(1, 0, 4'h7, 8'h00, r);
    chk(r[0], 1'b1, "output flag set");
    u_host_model.bus(1, 0, {1'b0, 2'($random(seed)), 1'b0}, 8'h00, r);
    chk(r, b, "sense");
    u_host_model.bus(1, 0, 4'h3, 8'h00, r);
    chk(r[1:0], 2'h0, "flags clear");
  endtask
  task automatic dma(input bit rd, input logic [7:0] v);
    for (int i = 0; i < 60 && dma_request_o !== 1'b1; i++)
      @(posedge ref_clk_i);
    chk(dma_request_o, 1'b1, "request");
    u_host_model.bus(rd, 1, {1'b0, 3'($random(seed))}, v, r);
    if (rd) chk(r, rq.pop_front(), "data");
  endtask
  initial begin
    repeat (5) @(posedge ref_clk_i);
    srst_i <= 1'b0;
    buffer_ready_i <= 1'b1;
    u_host_model.bus(1, 0, 4'h5, 8'h00, r);
    chk(r, 8'h80, "status after reset");
    put(1, 8'h06);
    put(0, 8'($random(seed)));
    sense;
    put(1, tape_port_pkg::transfer_begin_cmd);
    put(0, 8'h00);
    repeat (4) @(posedge ref_clk_i);
    chk(dma_request_o, 1'b0, "begin outside transfer");
    $display("simple command test done");
    for (int k = 0; k < 4; k++) begin
      case (k)
        0: c = tape_port_pkg::CMD_WRITE_BLOCK;
        1: c = tape_port_pkg::CMD_READ_BLOCK;
        2: c = tape_port_pkg::CMD_WRITE_RAM;
        default: c = tape_port_pkg::CMD_READ_RAM;
      endcase
      put(1, c);
      put(0, 8'h00);
      put(1, tape_port_pkg::transfer_begin_cmd);
      repeat (4) @(posedge ref_clk_i);
      chk(dma_request_o, 1'b0, "data before parameter");
      put(0, 8'h00);
      if (k[0]) begin
        for (int j = 0; j < 2; j++) begin
          rd_data_i <= 8'($random(seed));
          rd_valid_i <= 1'b1;
          for (int i = 0; i < 20; i++) begin
            @(posedge ref_clk_i);
            if (rd_ready_o === 1'b1) break;
          end
          rq.push_back(rd_data_i);
        end
        rd_valid_i <= 1'b0;
        @(posedge ref_clk_i);
        chk(rd_ready_o, 1'b0, "buffer full");
        for (int j = 0; j < 2; j++) dma(1, 8'h00);
      end else begin
        for (int j = 0; j < 3; j++) begin
          b = 8'($random(seed));
          wq.push_back(b);
          dma(0, b);
        end
        for (int i = 0; i < 60 && wq.size() > 0; i++) @(posedge ref_clk_i);
        chk(9'(wq.size()), 9'h000, "drained");
      end
      if (k == 3) begin
        hard_error_i <= 1'b1;
        @(posedge ref_clk_i);
        hard_error_i <= 1'b0;
        @(posedge ref_clk_i);
        chk(dma_terminate_o, 1'b1, "terminate");
      end else begin
        put(1, tape_port_pkg::transfer_end_cmd);
        put(0, 8'h00);
      end
      sense;
      $display("transfer test %0d done", k);
    end
    report_and_stop;
  end
  // Roughly thirty times the expected run; a hang counts as a mismatch.
  initial begin
    #100000;
    errors++;
    report_and_stop;
  end
endmodule // test_tape_host_command_port
bind tape_host_command_port tape_port_chk #(.WIDE_HOST(WIDE_HOST))
  u_tape_port_chk (.*);
